//--- rtl/sipo_defines.vh
// constants for the serial-in parallel-out latch block
`ifndef SIPO_DEFINES_VH
`define SIPO_DEFINES_VH
`define SIPO_WIDTH 8
`define SIPO_CHAIN_RST 8'h00
`define SIPO_HOLD_RST 8'h00
`define SIPO_IDLE_LOW 1'h0
`define SIPO_IDLE_HIGH 1'h1
`define SIPO_OD_VALUE 1'h0
`define SIPO_RELEASED 1'h1
`define SIPO_CAS_RST 1'h0
`endif

//--- rtl/sipo_sync.v
// two-flop synchroniser with rising-edge detect for one pin
`timescale 1ns/10ps
module sipo_sync
#(
    parameter RST_LVL = 1'h0 // idle level of the pin, held through reset
)
(
    input wire mclk_i, // system clock
    input wire rst_b_i, // async reset, active low
    input wire pin_i, // asynchronous pin
    output wire level_o, // synchronised level
    output wire rise_o // one-cycle pulse on rising edge
);
reg meta_r;
reg sync_r;
reg prev_r;
always @(posedge mclk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        meta_r <= RST_LVL;
        sync_r <= RST_LVL;
        prev_r <= RST_LVL;
    end
    else
    begin
        meta_r <= pin_i;
        sync_r <= meta_r;
        prev_r <= sync_r;
    end
end
assign level_o = sync_r;
assign rise_o = sync_r & ~prev_r;
endmodule

//--- rtl/sipo_latch.v
// serial-in parallel-out shifter with holding register and open-drain outputs
`timescale 1ns/10ps
`include "sipo_defines.vh"
module sipo_latch
#(
    parameter WIDTH = `SIPO_WIDTH
)
(
    input wire mclk_i, // 50 MHz system clock
    input wire rst_b_i, // async reset, active low
    input wire serial_in_i, // serial data pin
    input wire shift_clock_i, // shift clock pin
    input wire hold_clock_i, // holding-register clock pin
    input wire chain_clear_n_i, // chain clear pin, active low
    input wire out_enable_n_i, // output enable pin, active low
    output reg cascade_serial_out_o, // push-pull last chain stage
    output reg [WIDTH-1:0] par_out_o, // open-drain output value (always 0)
    output reg [WIDTH-1:0] par_oe_n_o // per-pin enable, low = pulling low
);

////////////////////////////////////////////////////////////////////////
wire ser_lvl;
wire sclk_rise;
wire hclk_rise;
wire clr_n_lvl;
wire oe_n_lvl;
wire clear_active;
wire shift_take;
wire cascade_nxt;
wire [WIDTH-1:0] stage_in;
wire [WIDTH-1:0] par_out_nxt;
wire [WIDTH-1:0] par_oe_n_nxt;
reg [WIDTH-1:0] chain_r;
reg [WIDTH-1:0] chain_nxt;
reg [WIDTH-1:0] hold_r;
reg [WIDTH-1:0] hold_nxt;

////////////////////////////////////////////////////////////////////////
// all pins share the same two-flop delay so data keeps its alignment to the clocks
// each synchroniser resets to its pin's idle level: no false edge or enable after reset
sipo_sync
#(
    .RST_LVL(`SIPO_IDLE_LOW)
)
u_ser
(
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(serial_in_i),
    .level_o(ser_lvl),
    .rise_o()
);

sipo_sync
#(
    .RST_LVL(`SIPO_IDLE_LOW)
)
u_sclk
(
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(shift_clock_i),
    .level_o(),
    .rise_o(sclk_rise)
);

sipo_sync
#(
    .RST_LVL(`SIPO_IDLE_LOW)
)
u_hclk
(
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(hold_clock_i),
    .level_o(),
    .rise_o(hclk_rise)
);

sipo_sync
#(
    .RST_LVL(`SIPO_IDLE_HIGH)
)
u_clr
(
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(chain_clear_n_i),
    .level_o(clr_n_lvl),
    .rise_o()
);

sipo_sync
#(
    .RST_LVL(`SIPO_IDLE_HIGH)
)
u_oe
(
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(out_enable_n_i),
    .level_o(oe_n_lvl),
    .rise_o()
);

////////////////////////////////////////////////////////////////////////
// clear is a synchronised level, so "immediate" costs the sync delay
assign clear_active = ~clr_n_lvl;
// shift rises while clear is low are dropped, not queued
assign shift_take = sclk_rise & clr_n_lvl;

////////////////////////////////////////////////////////////////////////
// per-bit wiring: stage feed, open-drain value and pin enable
genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
        if (i == 0)
        begin : g_first
            assign stage_in[i] = ser_lvl;
        end
        else
        begin : g_next
            assign stage_in[i] = chain_r[i-1];
        end
        // only ever pulls low; a released pin is lifted by the board
        assign par_out_nxt[i] = `SIPO_OD_VALUE;
        assign par_oe_n_nxt[i] = oe_n_lvl | hold_nxt[i];
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// separate edge detectors let shift and load act independently
always @*
begin
    chain_nxt = chain_r;
    if (clear_active)
    begin
        chain_nxt = `SIPO_CHAIN_RST;
    end
    else if (shift_take)
    begin
        chain_nxt = stage_in;
    end
end

// load sees the chain before any shift in the same cycle, as with real edge flops
always @*
begin
    hold_nxt = hold_r;
    if (hclk_rise)
    begin
        hold_nxt = chain_r;
    end
end

assign cascade_nxt = chain_nxt[WIDTH-1];

////////////////////////////////////////////////////////////////////////
// storage flops; the enable never reaches them
always @(posedge mclk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        chain_r <= `SIPO_CHAIN_RST;
    end
    else
    begin
        chain_r <= chain_nxt;
    end
end

always @(posedge mclk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        hold_r <= `SIPO_HOLD_RST;
    end
    else
    begin
        hold_r <= hold_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// outputs come straight from flops, fed from next state to save a cycle
always @(posedge mclk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        cascade_serial_out_o <= `SIPO_CAS_RST;
    end
    else
    begin
        cascade_serial_out_o <= cascade_nxt;
    end
end

always @(posedge mclk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        par_out_o <= {WIDTH{`SIPO_OD_VALUE}};
    end
    else
    begin
        par_out_o <= par_out_nxt;
    end
end

// enable only gates the drive, never the stored data
always @(posedge mclk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        par_oe_n_o <= {WIDTH{`SIPO_RELEASED}};
    end
    else
    begin
        par_oe_n_o <= par_oe_n_nxt;
    end
end

endmodule

//--- tb/sipo_latch_asserts.sv
// port assertions for the latch
`timescale 1ns/10ps
module sipo_latch_asserts #(parameter WIDTH = 8) (
    input wire mclk_i, rst_b_i, serial_in_i, shift_clock_i, hold_clock_i, chain_clear_n_i, out_enable_n_i,
    input wire cascade_serial_out_o,
    input wire [WIDTH-1:0] par_out_o, par_oe_n_o);
    // short aliases keep each property on one line
    wire cas = cascade_serial_out_o, sck = shift_clock_i, hck = hold_clock_i;
    wire clr = chain_clear_n_i, oen = out_enable_n_i;
    wire [WIDTH-1:0] pin = par_oe_n_o;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    property p_4; $rose(cas) |-> $past(sck, 3); endproperty
    a_4: assert property (p_4) else $error("stray rise");
    property p_9; $fell(cas) |-> $past(sck, 3) || !$past(clr, 3); endproperty
    a_9: assert property (p_9) else $error("stray fall");
    property p_6; !clr [*3] |=> !cas; endproperty
    a_6: assert property (p_6) else $error("no clear");
    property p_7; oen [*3] |=> &pin; endproperty
    a_7: assert property (p_7) else $error("not off");
    property p_10; par_out_o == 0; endproperty
    a_10: assert property (p_10) else $error("drives high");
    property p_8; (!sck && clr) [*4] |-> $stable(cas); endproperty
    a_8: assert property (p_8) else $error("chain moved");
    property p_11; (!hck && !oen) [*5] |-> $stable(pin); endproperty
    a_11: assert property (p_11) else $error("hold moved");
    property p_5; !oen [*6] ##0 $changed(pin) |-> $past(hck, 3); endproperty
    a_5: assert property (p_5) else $error("stray load");
endmodule

//--- tb/sipo_ctrl_model.sv
// controller model: byte msb first, then one holding pulse
`timescale 1ns/10ps
module sipo_ctrl_model
(
    input wire clk_i, // bench clock
    output reg ser_o, // serial data to the block
    output reg sck_o, // shift clock, 160 ns period
    output reg hck_o // holding clock
);
    initial
    begin
        ser_o = 1'b0;
        sck_o = 1'b0;
        hck_o = 1'b0;
    end
    task tick(input integer n);
        repeat (n) @(posedge clk_i) #1;
    endtask
    // data set 80 ns ahead of each rise; clocks idle low between frames
    task send(input [7:0] d);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
            begin
                ser_o = d[i];
                tick(4);
                sck_o = 1'b1;
                tick(4);
                sck_o = 1'b0;
            end
            tick(4);
            hck_o = 1'b1;
            tick(4);
            hck_o = 1'b0;
            tick(4);
        end
    endtask
endmodule

//--- tb/tb_sipo_latch.sv
// latch testbench
`timescale 1ns/10ps
module tb_sipo_latch;
    reg mclk_i;
    reg rst_b_i;
    reg chain_clear_n_i;
    reg out_enable_n_i;
    wire serial_in_i;
    wire shift_clock_i;
    wire hold_clock_i;
    wire cascade_serial_out_o;
    wire [7:0] par_out_o;
    wire [7:0] par_oe_n_o;
    integer fails;
    integer compares;
    sipo_ctrl_model m_u
    (
        .clk_i(mclk_i),
        .ser_o(serial_in_i),
        .sck_o(shift_clock_i),
        .hck_o(hold_clock_i)
    );
    sipo_latch dut_u
    (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .serial_in_i(serial_in_i),
        .shift_clock_i(shift_clock_i),
        .hold_clock_i(hold_clock_i),
        .chain_clear_n_i(chain_clear_n_i),
        .out_enable_n_i(out_enable_n_i),
        .cascade_serial_out_o(cascade_serial_out_o),
        .par_out_o(par_out_o),
        .par_oe_n_o(par_oe_n_o)
    );
    initial
    begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    task chk(input [23:0] n, input [7:0] e, g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task report_and_stop;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task t_load;
        out_enable_n_i = 1'b0;
        m_u.send(8'ha5);
        chk("hld", 8'ha5, par_oe_n_o);
        chk("cas", 8'h01, cascade_serial_out_o);
        chk("out", 8'h00, par_out_o);
        out_enable_n_i = 1'b1;
        m_u.tick(5);
        chk("off", 8'hff, par_oe_n_o);
        out_enable_n_i = 1'b0;
        m_u.tick(5);
        chk("on", 8'ha5, par_oe_n_o);
    endtask
    task t_clear;
        chain_clear_n_i = 1'b0;
        m_u.tick(5);
        chk("kep", 8'ha5, par_oe_n_o);
        chk("cz", 8'h00, cascade_serial_out_o);
        m_u.send(8'h3c);
        chk("clr", 8'h00, par_oe_n_o);
        chain_clear_n_i = 1'b1;
        m_u.send(8'hc3);
        chk("nxt", 8'hc3, par_oe_n_o);
        chk("cs2", 8'h01, cascade_serial_out_o);
    endtask
    initial
    begin
        rst_b_i = 1'b0;
        chain_clear_n_i = 1'b1;
        out_enable_n_i = 1'b1;
        fails = 0;
        compares = 0;
        repeat (5) @(posedge mclk_i);
        #1 rst_b_i = 1'b1;
        t_load;
        t_clear;
        report_and_stop;
    end
endmodule
bind sipo_latch sipo_latch_asserts #(.WIDTH(WIDTH)) chk_u (.*);
